// ### shared/lpdbr_pkg.sv
// Purpose: constants and types of the lpddr burst read path
// Assumes: link clock period given by LINK_PERIOD_PS
// Notes: the mode struct layout fixes the mode register field positions
package lpdbr_pkg;
  localparam int unsigned LINK_PERIOD_PS = 32000;
  localparam int unsigned ACT_GAP_PS = 10000;
  localparam int unsigned ACT_GAP_FAST_PS = 7500;
  localparam int unsigned ACT_GAP_MIN_NCK = 4;
  localparam int unsigned FAW_PS = 40000;
  localparam int unsigned FAW_FAST_PS = 30000;
  localparam int unsigned ACT_GAP_RU = (ACT_GAP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int unsigned ACT_GAP_FAST_RU = (ACT_GAP_FAST_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int unsigned ACT_GAP_CYC = (ACT_GAP_RU > ACT_GAP_MIN_NCK) ? ACT_GAP_RU : ACT_GAP_MIN_NCK;
  localparam int unsigned ACT_GAP_FAST_CYC =
    (ACT_GAP_FAST_RU > ACT_GAP_MIN_NCK) ? ACT_GAP_FAST_RU : ACT_GAP_MIN_NCK;
  localparam int unsigned FAW_CYC = (FAW_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int unsigned FAW_FAST_CYC = (FAW_FAST_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int unsigned FAW_ACT_MAX = 4;
  localparam logic [3:0] PREAMBLE_CK = 4'h2;
  localparam logic [3:0] BL16_CK = 4'h8;
  localparam logic [4:0] BL32_CK = 5'h10;
  localparam logic [5:0] RL_MIN = 6'h03;
  localparam logic [5:0] RL_RST = 6'h0a;
  localparam int unsigned DL_LEN = 64;
  localparam int unsigned RQ_DEPTH = 8;
  localparam logic [1:0] CA_ACT1 = 2'h1;
  localparam logic [1:0] CA_ACT2 = 2'h3;
  localparam logic [4:0] CA_RD1 = 5'h02;
  localparam logic [4:0] CA_CAS2 = 5'h12;
  localparam logic [4:0] CA_PRE = 5'h10;
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_REFRESH = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CONTROL = 8'h0c;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int unsigned FLG_ACT_GAP = 0;
  localparam int unsigned FLG_FAW = 1;
  localparam int unsigned FLG_CLOSED = 2;
  localparam int unsigned FLG_OVERLAP = 3;
  typedef struct packed {
    logic fast;
    logic otf;
    logic bl32;
    logic post_ext;
    logic pre_tog;
    logic [5:0] rl;
  } lpdbr_mode_type;
  typedef struct packed {
    logic clr_tgl;
    lpdbr_mode_type mode;
  } lpdbr_cfg_type;
  typedef struct packed {
    logic [15:0] rd_count;
    logic [7:0] open_banks;
    logic [3:0] flags;
  } lpdbr_stat_type;
  typedef struct packed {
    logic [2:0] bank;
    logic [9:0] col;
    logic bl32;
  } lpdbr_rinfo_type;
  typedef struct packed {
    logic first;
    logic second;
  } lpdbr_half_type;
  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
  } lpdbr_beat_type;
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_PRE, SEQ_DATA, SEQ_PEXT, SEQ_POST} lpdbr_seq_type;
  localparam lpdbr_mode_type MODE_RST = '{fast: 1'b0, otf: 1'b0, bl32: 1'b0, post_ext: 1'b0,
                                          pre_tog: 1'b0, rl: RL_RST};
  localparam lpdbr_cfg_type CFG_RST = '{clr_tgl: 1'b0, mode: MODE_RST};
endpackage

// ### hdl/lpdbr_word_cdc.sv
// Purpose: carries a word between clock domains by toggle handshake
// Assumes: data is resent continuously from the source
// Notes: hold register is stable while the destination samples it
`timescale 1ns/100ps
`default_nettype none
module lpdbr_word_cdc #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic src_clk_i, // source clock
  input wire logic src_rst_n_i, // source reset
  input wire logic [W-1:0] data_i, // source word
  input wire logic dst_clk_i, // destination clock
  input wire logic dst_rst_n_i, // destination reset
  output logic [W-1:0] data_o // destination word
);
  logic req_q, ack1_q, ack2_q, req1_q, req2_q, seen_q;
  logic [W-1:0] hold_q;
  always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
    if (!src_rst_n_i) begin
      req_q <= 1'b0;
      hold_q <= RST;
      ack1_q <= 1'b0;
      ack2_q <= 1'b0;
    end else begin
      ack1_q <= seen_q;
      ack2_q <= ack1_q;
      if (ack2_q == req_q) begin
        hold_q <= data_i;
        req_q <= ~req_q;
      end
    end
  end
  always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
    if (!dst_rst_n_i) begin
      req1_q <= 1'b0;
      req2_q <= 1'b0;
      seen_q <= 1'b0;
      data_o <= RST;
    end else begin
      req1_q <= req_q;
      req2_q <= req1_q;
      if (req2_q != seen_q) begin
        seen_q <= req2_q;
        data_o <= hold_q;
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/lpdbr_act_guard.sv
// Purpose: watches activate spacing on the link
// Assumes: act_i pulses once per completed activate
// Notes: violation outputs are one-cycle pulses, one edge late
`timescale 1ns/100ps
`default_nettype none
module lpdbr_act_guard (
  input wire logic clk_i, // link clock
  input wire logic rst_n_i, // async reset
  input wire logic act_i, // activate completed
  input wire logic fast_i, // fastest grade timings
  output logic gap_viol_o, // activates too close
  output logic faw_viol_o // fifth activate in window
);
  localparam int unsigned HW = lpdbr_pkg::FAW_CYC + 1;
  logic [7:0] gap_q;
  logic [HW-1:0] hist_q;
  int unsigned win;
  int unsigned need;
  int unsigned cnt;
  always_comb begin
    win = fast_i ? lpdbr_pkg::FAW_FAST_CYC : lpdbr_pkg::FAW_CYC;
    need = fast_i ? lpdbr_pkg::ACT_GAP_FAST_CYC : lpdbr_pkg::ACT_GAP_CYC;
    cnt = 0;
    for (int i = 0; i < HW; i++) begin
      if ((i + 1 < win) && hist_q[i]) begin
        cnt = cnt + 1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_q <= 8'hff;
      hist_q <= '0;
      gap_viol_o <= 1'b0;
      faw_viol_o <= 1'b0;
    end else begin
      hist_q <= {hist_q[HW-2:0], act_i};
      gap_q <= act_i ? 8'h00 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
      gap_viol_o <= act_i && (32'(gap_q) + 1 < need);
      faw_viol_o <= act_i && (cnt >= lpdbr_pkg::FAW_ACT_MAX);
    end
  end
endmodule
`default_nettype wire

// ### hdl/lpdbr_top.sv
// Purpose: read path of a low power ddr channel with ahb-lite settings
// Assumes: link reset shares rst_n_i; ca bus synchronous to ck_i
// Notes: strobe, strobe enable and data outputs carry two half-cycle values each; the data enable is one bit
`timescale 1ns/100ps
`default_nettype none
module lpdbr_top (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic hsel_i, // ahb select
  input wire logic [31:0] haddr_i, // ahb address
  input wire logic [1:0] htrans_i, // ahb transfer type
  input wire logic hwrite_i, // ahb write
  input wire logic [2:0] hsize_i, // ahb size
  input wire logic [31:0] hwdata_i, // ahb write data
  input wire logic hready_i, // ahb ready in
  output logic hreadyout_o, // ahb ready out
  output logic hresp_o, // ahb response
  output logic [31:0] hrdata_o, // ahb read data
  input wire logic [2:0] refresh_rate_i, // refresh rate level
  input wire logic ck_i, // link clock
  input wire logic cke_i, // clock enable pin
  input wire logic cs_i, // chip select
  input wire logic [5:0] ca_i, // command address
  output lpdbr_pkg::lpdbr_half_type dqs_o, // strobe halves
  output lpdbr_pkg::lpdbr_half_type dqs_oe_o, // strobe enables
  output lpdbr_pkg::lpdbr_beat_type dq_o, // data halves
  output logic dq_oe_o // data enable
);

////////////////////////////////////////////////////////////////////////////////
// system domain: ahb-lite slave and registers

  logic acc_c;
  logic wr_q;
  logic [7:0] wa_q;
  lpdbr_pkg::lpdbr_mode_type mode_q;
  lpdbr_pkg::lpdbr_mode_type mode_v;
  logic clr_tgl_q;
  logic [2:0] rr1_q, rr2_q;
  lpdbr_pkg::lpdbr_stat_type stat_s;
  lpdbr_pkg::lpdbr_cfg_type cfg_s;

  assign acc_c = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign cfg_s = '{clr_tgl: clr_tgl_q, mode: mode_q};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= acc_c & hwrite_i & (hsize_i == lpdbr_pkg::HSIZE_WORD);
      wa_q <= haddr_i[7:0];
    end
  end

  // settings written by the memory controller's software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= lpdbr_pkg::MODE_RST;
      clr_tgl_q <= 1'b0;
    end else if (wr_q) begin
      if (wa_q == lpdbr_pkg::REG_MODE) begin
        mode_q <= hwdata_i[$bits(mode_q)-1:0];
      end
      if (wa_q == lpdbr_pkg::REG_CONTROL && hwdata_i[0]) begin
        clr_tgl_q <= ~clr_tgl_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rr1_q <= 3'h0;
      rr2_q <= 3'h0;
    end else begin
      rr1_q <= refresh_rate_i;
      rr2_q <= rr1_q;
    end
  end

  // a read right after a mode write sees the new value
  always_comb begin
    mode_v = mode_q;
    if (wr_q && wa_q == lpdbr_pkg::REG_MODE) begin
      mode_v = hwdata_i[$bits(mode_q)-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (acc_c && !hwrite_i) begin
      case (haddr_i[7:0])
        lpdbr_pkg::REG_MODE: hrdata_o <= {21'h000000, mode_v};
        lpdbr_pkg::REG_REFRESH: hrdata_o <= {29'h00000000, rr2_q};
        lpdbr_pkg::REG_STATUS: hrdata_o <= {stat_s.rd_count, stat_s.open_banks, 4'h0, stat_s.flags};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////////////
// crossings between the two domains

  lpdbr_pkg::lpdbr_cfg_type cfg_l;
  lpdbr_pkg::lpdbr_stat_type stat_l;
  lpdbr_pkg::lpdbr_mode_type cfg;

  lpdbr_word_cdc #(
    .W($bits(lpdbr_pkg::lpdbr_cfg_type)),
    .RST(lpdbr_pkg::CFG_RST)
  ) u_cfg_cdc (
    .src_clk_i(clk_i),
    .src_rst_n_i(rst_n_i),
    .data_i(cfg_s),
    .dst_clk_i(ck_i),
    .dst_rst_n_i(rst_n_i),
    .data_o(cfg_l)
  );

  lpdbr_word_cdc #(
    .W($bits(lpdbr_pkg::lpdbr_stat_type)),
    .RST('0)
  ) u_stat_cdc (
    .src_clk_i(ck_i),
    .src_rst_n_i(rst_n_i),
    .data_i(stat_l),
    .dst_clk_i(clk_i),
    .dst_rst_n_i(rst_n_i),
    .data_o(stat_s)
  );

  assign cfg = cfg_l.mode;

////////////////////////////////////////////////////////////////////////////////
// link domain: two-cycle command decode and bank state

  logic ph_q;
  logic [5:0] c1_q;
  logic first_c, act1_c, act2_c, rd1_c, cas2_c, pre_c, rd_done_c, push_c;
  logic [2:0] act_bank_q, rd_bank_q;
  logic rd_arm_q, rd_c9_q, rd_bl32_q;
  logic [7:0] open_q;
  logic [15:0] rdcnt_q;

  always_comb begin
    first_c = cke_i & cs_i & ~ph_q;
    act1_c = ph_q & (c1_q[1:0] == lpdbr_pkg::CA_ACT1);
    act2_c = ph_q & (c1_q[1:0] == lpdbr_pkg::CA_ACT2);
    rd1_c = ph_q & (c1_q[4:0] == lpdbr_pkg::CA_RD1);
    cas2_c = ph_q & (c1_q[4:0] == lpdbr_pkg::CA_CAS2);
    pre_c = ph_q & (c1_q[4:0] == lpdbr_pkg::CA_PRE);
    rd_done_c = cas2_c & rd_arm_q;
    push_c = rd_done_c & open_q[rd_bank_q];
  end

  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_q <= 1'b0;
      c1_q <= 6'h00;
    end else begin
      ph_q <= first_c;
      if (first_c) begin
        c1_q <= ca_i;
      end
    end
  end

  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_arm_q <= 1'b0;
      rd_bank_q <= 3'h0;
      rd_c9_q <= 1'b0;
      rd_bl32_q <= 1'b0;
      act_bank_q <= 3'h0;
    end else if (ph_q) begin
      rd_arm_q <= rd1_c;
      if (rd1_c) begin
        rd_bank_q <= ca_i[2:0];
        rd_c9_q <= ca_i[5];
        rd_bl32_q <= cfg.otf ? c1_q[5] : cfg.bl32;
      end
      if (act1_c) begin
        act_bank_q <= ca_i[2:0];
      end
    end
  end

  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      open_q <= 8'h00;
    end else if (act2_c) begin
      open_q[act_bank_q] <= 1'b1;
    end else if (pre_c) begin
      if (ca_i[5]) begin
        open_q <= 8'h00;
      end else begin
        open_q[ca_i[2:0]] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdcnt_q <= 16'h0000;
    end else if (push_c) begin
      rdcnt_q <= rdcnt_q + 16'h0001;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// link domain: read latency line and pending-read queue

  lpdbr_pkg::lpdbr_rinfo_type q_mem [lpdbr_pkg::RQ_DEPTH];
  logic [2:0] wp_q, rp_q;
  logic [lpdbr_pkg::DL_LEN-1:0] dl_q;
  logic [5:0] rl_eff;
  logic launch_c;
  lpdbr_pkg::lpdbr_rinfo_type pop_c;

  always_comb begin
    rl_eff = (cfg.rl < lpdbr_pkg::RL_MIN) ? lpdbr_pkg::RL_MIN : cfg.rl;
    launch_c = dl_q[rl_eff - lpdbr_pkg::RL_MIN];
    pop_c = q_mem[rp_q];
  end

  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dl_q <= '0;
      wp_q <= 3'h0;
      rp_q <= 3'h0;
    end else begin
      dl_q <= {dl_q[lpdbr_pkg::DL_LEN-2:0], push_c};
      if (push_c) begin
        wp_q <= wp_q + 3'h1;
      end
      if (launch_c) begin
        rp_q <= rp_q + 3'h1;
      end
    end
  end

  always_ff @(posedge ck_i) begin
    if (push_c) begin
      q_mem[wp_q] <= '{bank: rd_bank_q, col: {rd_c9_q, c1_q[5], ca_i, 2'b00}, bl32: rd_bl32_q};
    end
  end

////////////////////////////////////////////////////////////////////////////////
// link domain: strobe and data sequencer

  lpdbr_pkg::lpdbr_seq_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [4:0] off_q, off_d;
  lpdbr_pkg::lpdbr_rinfo_type cur_q, cur_d, nxt_q, nxt_d;
  logic pend_q, pend_d, ovl_c;

  function automatic logic [3:0] last_of(input logic bl32);
    logic [4:0] n;
    n = bl32 ? lpdbr_pkg::BL32_CK : {1'b0, lpdbr_pkg::BL16_CK};
    last_of = 4'(n - 5'h01);
  endfunction

  function automatic logic [15:0] word_of(input lpdbr_pkg::lpdbr_rinfo_type r, input logic [4:0] off);
    logic [9:0] c;
    c = r.col + {5'h00, off};
    word_of = {r.bank, 3'h0, c};
  endfunction

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    off_d = off_q;
    cur_d = cur_q;
    nxt_d = nxt_q;
    pend_d = pend_q;
    ovl_c = 1'b0;
    case (st_q)
      lpdbr_pkg::SEQ_IDLE, lpdbr_pkg::SEQ_PEXT, lpdbr_pkg::SEQ_POST: begin
        if (launch_c) begin
          st_d = lpdbr_pkg::SEQ_PRE;
          cnt_d = lpdbr_pkg::PREAMBLE_CK - 4'h1;
          cur_d = pop_c;
        end else if (st_q == lpdbr_pkg::SEQ_PEXT) begin
          st_d = lpdbr_pkg::SEQ_POST;
        end else begin
          st_d = lpdbr_pkg::SEQ_IDLE;
        end
      end
      lpdbr_pkg::SEQ_PRE: begin
        ovl_c = launch_c;
        if (cnt_q == 4'h0) begin
          st_d = lpdbr_pkg::SEQ_DATA;
          cnt_d = last_of(cur_q.bl32);
          off_d = 5'h00;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      lpdbr_pkg::SEQ_DATA: begin
        off_d = off_q + 5'h02;
        if (launch_c && pend_q) begin
          ovl_c = 1'b1;
        end else if (launch_c && cnt_q != 4'h0) begin
          pend_d = 1'b1;
          nxt_d = pop_c;
        end
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (pend_q) begin
          st_d = lpdbr_pkg::SEQ_DATA;
          cur_d = nxt_q;
          pend_d = 1'b0;
          cnt_d = last_of(nxt_q.bl32);
          off_d = 5'h00;
        end else if (launch_c) begin
          st_d = lpdbr_pkg::SEQ_PRE;
          cnt_d = lpdbr_pkg::PREAMBLE_CK - 4'h1;
          cur_d = pop_c;
        end else begin
          st_d = cfg.post_ext ? lpdbr_pkg::SEQ_PEXT : lpdbr_pkg::SEQ_POST;
        end
      end
      default: begin
        st_d = lpdbr_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= lpdbr_pkg::SEQ_IDLE;
      cnt_q <= 4'h0;
      off_q <= 5'h00;
      cur_q <= '0;
      nxt_q <= '0;
      pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      off_q <= off_d;
      cur_q <= cur_d;
      nxt_q <= nxt_d;
      pend_q <= pend_d;
    end
  end

  // pins follow the next state so every output leaves a flip-flop
  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dqs_o <= '0;
      dqs_oe_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
    end else begin
      dqs_o <= '0;
      dqs_oe_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      case (st_d)
        lpdbr_pkg::SEQ_PRE: begin
          dqs_oe_o <= 2'b11;
          dqs_o <= cfg.pre_tog ? 2'b10 : 2'b00;
        end
        lpdbr_pkg::SEQ_DATA: begin
          dqs_oe_o <= 2'b11;
          dqs_o <= 2'b10;
          dq_oe_o <= 1'b1;
          dq_o.first <= word_of(cur_d, off_d);
          dq_o.second <= word_of(cur_d, off_d + 5'h01);
        end
        lpdbr_pkg::SEQ_PEXT: begin
          dqs_oe_o <= 2'b11;
        end
        lpdbr_pkg::SEQ_POST: begin
          dqs_oe_o <= 2'b10;
        end
        default: begin
          dqs_oe_o <= 2'b00;
        end
      endcase
    end
  end

////////////////////////////////////////////////////////////////////////////////
// link domain: activate checks and sticky status

  logic gap_ev, faw_ev;
  logic clr_seen_q, clr_c;
  logic [3:0] ev_c;
  logic [3:0] flags_q;

  lpdbr_act_guard u_guard (
    .clk_i(ck_i),
    .rst_n_i(rst_n_i),
    .act_i(act2_c),
    .fast_i(cfg.fast),
    .gap_viol_o(gap_ev),
    .faw_viol_o(faw_ev)
  );

  always_comb begin
    clr_c = cfg_l.clr_tgl ^ clr_seen_q;
    ev_c = 4'h0;
    ev_c[lpdbr_pkg::FLG_ACT_GAP] = gap_ev;
    ev_c[lpdbr_pkg::FLG_FAW] = faw_ev;
    ev_c[lpdbr_pkg::FLG_CLOSED] = rd_done_c & ~open_q[rd_bank_q];
    ev_c[lpdbr_pkg::FLG_OVERLAP] = ovl_c;
  end

  // a new event in the clearing cycle stays set
  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_seen_q <= 1'b0;
      flags_q <= 4'h0;
    end else begin
      clr_seen_q <= cfg_l.clr_tgl;
      flags_q <= (clr_c ? 4'h0 : flags_q) | ev_c;
    end
  end

  assign stat_l = '{rd_count: rdcnt_q, open_banks: open_q, flags: flags_q};

endmodule
`default_nettype wire

// ### verification/lpdbr_monitor.sv
// Purpose: link output checks of the burst read path
// Assumes: outputs registered on ck_i
// Notes: bound to lpdbr_top below
`timescale 1ns/100ps
`default_nettype none
module lpdbr_monitor (
  input wire logic ck_i, // link clock
  input wire logic rst_n_i, // async reset
  input wire lpdbr_pkg::lpdbr_half_type dqs_o, // strobe halves
  input wire lpdbr_pkg::lpdbr_half_type dqs_oe_o, // strobe enables
  input wire lpdbr_pkg::lpdbr_beat_type dq_o, // data halves
  input wire logic dq_oe_o // data enable
);
  logic [7:0] run_q;
  default clocking @(posedge ck_i);
  endclocking
  default disable iff (!rst_n_i);
  // length of the current data run
  always_ff @(posedge ck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 8'h00;
    end else begin
      run_q <= dq_oe_o ? run_q + 8'h01 : 8'h00;
    end
  end
  ////////////////////////////////////////
  a_pre_two_cycles:
    assert property ($rose(dq_oe_o) |-> $past(dqs_oe_o, 1) == 2'b11 && $past(dqs_oe_o, 2) == 2'b11)
      else $error("data without preamble");
  a_pre_level:
    assert property (dqs_oe_o == 2'b11 && !dq_oe_o |-> !dqs_o.second)
      else $error("preamble level wrong");
  a_data_strobe:
    assert property (dq_oe_o |-> dqs_oe_o == 2'b11 && dqs_o == 2'b10)
      else $error("strobe not aligned to data");
  a_beat_pair:
    assert property (dq_oe_o |-> !dq_o.first[0] && dq_o.second == dq_o.first + 16'h0001)
      else $error("beat order wrong");
  a_post_start:
    assert property ($fell(dq_oe_o) |-> dqs_oe_o.first && !dqs_o.second)
      else $error("no postamble after data");
  a_post_shape:
    assert property (dqs_oe_o == 2'b10 |-> (dqs_o == 2'b00 && !dq_oe_o) ##1 !dq_oe_o)
      else $error("postamble shape wrong");
  a_idle_quiet:
    assert property (!dqs_oe_o.first |-> !dqs_oe_o.second && !dq_oe_o)
      else $error("driving outside a read");
  a_burst_whole:
    assert property ($fell(dq_oe_o) |-> run_q != 8'h00 && run_q[2:0] == 3'h0)
      else $error("burst cut short");
  c_data: cover property ($rose(dq_oe_o));
  c_ext_post: cover property ($fell(dq_oe_o) && dqs_oe_o == 2'b11);
  c_long_run: cover property (dq_oe_o && run_q == 8'h10);
endmodule
bind lpdbr_top lpdbr_monitor mon_u (
  .ck_i(ck_i),
  .rst_n_i(rst_n_i),
  .dqs_o(dqs_o),
  .dqs_oe_o(dqs_oe_o),
  .dq_o(dq_o),
  .dq_oe_o(dq_oe_o)
);
`default_nettype wire

// ### verification/lpdbr_host_model.sv
// Purpose: host controller issuing link commands
// Assumes: commands change right after ck_i rises
// Notes: open bank record kept for read planning
`timescale 1ns/100ps
`default_nettype none
module lpdbr_host_model (
  input wire logic ck_i, // link clock
  output logic cke_o, // clock enable
  output logic cs_o, // chip select
  output logic [5:0] ca_o // command address
);
  logic [7:0] open_q = 8'h00;
  initial begin
    cke_o = 1'b0;
    cs_o = 1'b0;
    ca_o = 6'h00;
  end
  task automatic cmd(input logic [5:0] a, input logic [5:0] b);
    @(posedge ck_i);
    cke_o <= 1'b1;
    cs_o <= 1'b1;
    ca_o <= a;
    @(posedge ck_i);
    cs_o <= 1'b0;
    ca_o <= b;
  endtask
  // ca is ignored while cs is low outside a command's second cycle, so keep it moving
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ck_i);
      ca_o <= ~ca_o;
    end
  endtask
  task automatic act(input logic [2:0] bank);
    idle(lpdbr_pkg::ACT_GAP_CYC - 4);
    cmd({4'h0, lpdbr_pkg::CA_ACT1}, {3'h0, bank});
    cmd({4'h0, lpdbr_pkg::CA_ACT2}, 6'h00);
    open_q[bank] = 1'b1;
  endtask
  task automatic pre(input logic [2:0] bank);
    cmd({1'b0, lpdbr_pkg::CA_PRE}, {3'h0, bank});
    open_q[bank] = 1'b0;
  endtask
  task automatic rd(input logic [2:0] bank, input logic [9:0] col, input logic bl32, input logic rude);
    if (!open_q[bank] && !rude) begin
      act(bank);
    end
    cmd({bl32, lpdbr_pkg::CA_RD1}, {col[9], 2'b00, bank});
    cmd({col[8], lpdbr_pkg::CA_CAS2}, col[7:2]);
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Purpose: self-checking bench of the burst read path
// Assumes: one ahb slave, host model on the link
// Notes: a timeline holds the expected link outputs
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [10:0] mode;
    logic [2:0] rr;
    logic [2:0] bank;
    logic [9:0] col;
    logic cbl;
    logic [15:0] first;
  } lpdbr_row_type;
  lpdbr_row_type rows [0:5] = '{'{11'h00a, 3'h1, 3'h1, 10'h004, 1'b0, 16'h2004},
    '{11'h04c, 3'h2, 3'h2, 10'h3f7, 1'b0, 16'h43f4}, '{11'h086, 3'h3, 3'h7, 10'h108, 1'b0, 16'he108},
    '{11'h103, 3'h4, 3'h0, 10'h3fc, 1'b0, 16'h03fc}, '{11'h2c1, 3'h5, 3'h3, 10'h01b, 1'b1, 16'h6018},
    '{11'h70a, 3'h7, 3'h5, 10'h2a0, 1'b0, 16'ha2a0}};
  logic clk_i = 1'b0;
  logic ck_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic hsel_i = 1'b1;
  logic [31:0] hwdata_i = 32'h0;
  logic [2:0] refresh_rate_i = 3'h0;
  logic hreadyout_o, hresp_o, cke, cs, chk_en = 1'b0;
  logic [31:0] hrdata_o, rv;
  logic [5:0] ca;
  logic [10:0] m;
  lpdbr_pkg::lpdbr_half_type dqs_o, dqs_oe_o;
  lpdbr_pkg::lpdbr_beat_type dq_o;
  logic dq_oe_o;
  logic [36:0] tl [0:8191];
  int cyc = 0;
  int tmo = 0;
  int err_count = 0;
  int n_compared = 0;
  always #20 clk_i = ~clk_i;
  always #16 ck_i = ~ck_i;
  lpdbr_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .refresh_rate_i(refresh_rate_i),
    .ck_i(ck_i), .cke_i(cke), .cs_i(cs), .ca_i(ca), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o));
  lpdbr_host_model host_u (.ck_i(ck_i), .cke_o(cke), .cs_o(cs), .ca_o(ca));
  ////////////////////////////////////////
  task automatic chk(input logic [36:0] s, input logic [36:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rv = hrdata_o;
    chk({35'h0, hreadyout_o, hresp_o}, 37'h2);
  endtask
  // enter one read into the timeline, counted from the completing edge
  task automatic sched(input logic [15:0] f, input int rl, input int n, input logic tog, input logic ext);
    int e;
    logic [9:0] c;
    @(negedge ck_i);
    e = cyc + 1 + rl;
    for (int k = -2; k < 0; k++) begin
      if (tl[e + k][32] !== 1'b1) begin
        tl[e + k] = {2'b11, tog, 1'b0, 33'h0};
      end
    end
    for (int k = 0; k < n; k++) begin
      c = f[9:0] + 10'(2 * k);
      tl[e + k] = {5'h1d, f[15:10], c, f[15:10], c + 10'h001};
    end
    tl[e + n] = {ext ? 4'hc : 4'h8, 33'h0};
    if (ext) begin
      tl[e + n + 1] = {4'h8, 33'h0};
    end
  endtask
  task automatic seam(input logic [10:0] md, input int gap, input int n);
    ahb(1'b1, lpdbr_pkg::REG_MODE, {21'h0, md});
    repeat (12) @(posedge ck_i);
    host_u.rd(3'h1, 10'h010, 1'b0, 1'b0);
    sched(16'h2010, 10, n, 1'b0, 1'b0);
    host_u.idle(gap);
    host_u.rd(3'h2, 10'h020, 1'b0, 1'b0);
    sched(16'h4020, 10, n, 1'b0, 1'b0);
    host_u.idle(50);
  endtask
  ////////////////////////////////////////
  always @(posedge ck_i) cyc <= cyc + 1;
  always @(negedge ck_i) begin
    if (chk_en) begin
      chk({dqs_oe_o, dqs_o, dq_oe_o, dq_o}, tl[cyc[12:0]]);
    end
  end
  always @(posedge clk_i) begin
    tmo++;
    if (tmo == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    foreach (tl[i]) tl[i] = '0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk_en = 1'b1;
    foreach (rows[i]) begin
      @(posedge clk_i);
      refresh_rate_i <= rows[i].rr;
      m = rows[i].mode;
      ahb(1'b1, lpdbr_pkg::REG_MODE, {21'h0, m});
      ahb(1'b0, lpdbr_pkg::REG_MODE, 32'h0);
      chk({5'h0, rv}, {26'h0, m});
      ahb(1'b0, lpdbr_pkg::REG_REFRESH, 32'h0);
      chk({5'h0, rv}, {34'h0, rows[i].rr});
      repeat (12) @(posedge ck_i);
      host_u.rd(rows[i].bank, rows[i].col, rows[i].cbl, 1'b0);
      sched(rows[i].first, (m[5:0] < 6'h03) ? 3 : int'(m[5:0]), (m[9] ? rows[i].cbl : m[8]) ? 16 : 8, m[6], m[7]);
      host_u.idle(40);
    end
    seam(11'h00a, 4, 8);
    seam(11'h10a, 12, 16);
    // two bare activates two edges apart trip the gap flag
    host_u.cmd({4'h0, lpdbr_pkg::CA_ACT2}, 6'h00);
    host_u.cmd({4'h0, lpdbr_pkg::CA_ACT2}, 6'h00);
    host_u.pre(3'h5);
    host_u.rd(3'h4, 10'h000, 1'b0, 1'b1);
    host_u.idle(40);
    ahb(1'b0, lpdbr_pkg::REG_STATUS, 32'h0);
    chk({9'h0, rv[31:16], rv[15:8], rv[3:0]}, {9'h0, 16'h000a, host_u.open_q, 4'h5});
    ahb(1'b1, lpdbr_pkg::REG_CONTROL, 32'h1);
    repeat (30) @(posedge ck_i);
    ahb(1'b0, lpdbr_pkg::REG_STATUS, 32'h0);
    chk({33'h0, rv[3:0]}, 37'h0);
    ahb(1'b1, lpdbr_pkg::REG_REFRESH, 32'h0);
    ahb(1'b0, lpdbr_pkg::REG_REFRESH, 32'h0);
    chk({5'h0, rv}, 37'h7);
    ahb(1'b0, 8'h10, 32'h0);
    chk({5'h0, rv}, 37'h0);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    host_u.open_q = 8'h00;
    // undersized and deselected writes must leave the mode alone
    hsize_i <= 3'h0;
    ahb(1'b1, lpdbr_pkg::REG_MODE, 32'h0000_03ff);
    hsize_i <= lpdbr_pkg::HSIZE_WORD;
    hsel_i <= 1'b0;
    ahb(1'b1, lpdbr_pkg::REG_MODE, 32'h0000_03ff);
    hsel_i <= 1'b1;
    ahb(1'b0, lpdbr_pkg::REG_MODE, 32'h0);
    chk({5'h0, rv}, 37'h00a);
    host_u.rd(3'h1, 10'h004, 1'b0, 1'b0);
    sched(16'h2004, 10, 8, 1'b0, 1'b0);
    host_u.idle(40);
    tally_and_finish();
  end
endmodule
`default_nettype wire
